// *** include/timer_regs.vh ***
// constants for the multimode down counter timer
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
`define TMR_WIDTH        16
`define TMR_ALL_ONES     16'hffff
`define TMR_ALL_ZEROS    16'h0000
`define TMR_MODE_TIMER   2'h0
`define TMR_MODE_EVENT   2'h1
`define TMR_MODE_ONESHOT 2'h2
`define TMR_MODE_PWM     2'h3
`define TMR_DIV_DEFAULT  8
`endif

// *** design/count_source_divider.v ***
// count source tick generator
`timescale 1ns/1ps
`default_nettype none
module count_source_divider #(
  parameter integer DIV = 8
) (
  input  wire clock,
  input  wire rst,
  input  wire clockEnable,
  output reg  tick
);
  reg [15:0] divCount_reg;
  always @(posedge clock) begin
    if (rst) begin
      divCount_reg <= 16'h0000;
      tick         <= 1'b0;
    end else if (clockEnable) begin
      if (divCount_reg == DIV[15:0] - 16'h0001) begin
        divCount_reg <= 16'h0000;
        tick         <= 1'b1;
      end else begin
        divCount_reg <= divCount_reg + 16'h0001;
        tick         <= 1'b0;
      end
    end
  end
endmodule // count_source_divider
`default_nettype wire

// *** design/multimode_down_counter_timer.v ***
// 16-bit timer channel: timer, event counter, one-shot and pwm modes
// Function
// - timer mode read gives live count, all ones at the reload instant.
// - event mode reload read gives all ones on underflow, zeros on overflow.
// - a write while halted reads back unchanged until counting starts.
// - one-shot stop mid-count halts counter and copies reload value back.
// - one-shot stop mid-count drives output low and sets interrupt bit.
// - one-shot output follows trigger within one count-source period.
// - entering one-shot from reset, timer or event mode sets interrupt bit.
// - retrigger during one-shot gives one more down count, then reload.
// - entering pwm from reset, timer or event mode sets interrupt bit.
// - pwm stop drives high output low with interrupt; low stays unchanged.
`include "timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module multimode_down_counter_timer #(
  parameter integer DIV = `TMR_DIV_DEFAULT
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        clockEnable,
  input  wire [1:0]  modeSelect,
  input  wire        countStart,
  input  wire        freeRun,
  input  wire        countUp,
  input  wire        externalTrigger,
  input  wire        timer_trigger_input_pin,
  input  wire        counterWrite,
  input  wire [15:0] counterWriteData,
  input  wire        irqWriteZero,
  output reg  [15:0] counterReadData,
  output reg         timer_pulse_output_pin,
  output reg         irqRequest,
  output reg         countActive
);
  wire        tick;
  reg  [15:0] counter_reg;
  reg  [15:0] counter_next;
  reg  [15:0] reload_reg;
  reg  [15:0] reload_next;
  reg  [1:0]  modePrev_reg;
  reg         startPrev_reg;
  reg         pinPrev_reg;
  reg         trigPend_reg;
  reg         trigPend_next;
  reg         retrig_reg;
  reg         retrig_next;
  reg         reloadSoon_reg;
  reg         reloadSoon_next;
  reg         running_reg;
  reg         running_next;
  reg         out_next;
  reg         irqEvent;
  reg         readOverride;
  reg  [15:0] readValue;

  // one-shot and pwm share the running state, trigger-driven in one-shot only
  function isPulseMode;
    input [1:0] m;
    begin
      isPulseMode = (m == `TMR_MODE_ONESHOT) || (m == `TMR_MODE_PWM);
    end
  endfunction

  // timer and event modes count while the start flag stays set
  function isLevelMode;
    input [1:0] m;
    begin
      isLevelMode = (m == `TMR_MODE_TIMER) || (m == `TMR_MODE_EVENT);
    end
  endfunction

  // rising pin edges only, start flag both ways; pin history resets low like the idle pin
  wire pinEdge   = timer_trigger_input_pin & ~pinPrev_reg;
  wire startRise = countStart & ~startPrev_reg;
  wire startFall = ~countStart & startPrev_reg;
  // external trigger selects the pin, otherwise the start flag rise
  wire trigEvent = externalTrigger ? pinEdge : startRise;
  // a mode switch clears running state and holds the counter for that cycle
  wire modeChange = (modeSelect != modePrev_reg);
  // only a move from a level mode into a pulse mode raises the bit
  wire modeEntry  = modeChange && isPulseMode(modeSelect) && isLevelMode(modePrev_reg);

  // count source: one tick every DIV clocks
  count_source_divider #(
    .DIV (DIV)
  ) u_div (
    .clock       (clock),
    .rst         (rst),
    .clockEnable (clockEnable),
    .tick        (tick)
  );

  // next-state and read-port logic for all four modes
  always @* begin
    counter_next    = counter_reg;
    reload_next     = reload_reg;
    trigPend_next   = trigPend_reg;
    retrig_next     = retrig_reg;
    reloadSoon_next = reloadSoon_reg;
    running_next    = running_reg;
    out_next        = timer_pulse_output_pin;
    irqEvent        = 1'b0;
    readOverride    = 1'b0;
    readValue       = counter_reg;
    case (modeSelect)
      `TMR_MODE_TIMER: begin
        // output pin unused in the level modes
        out_next = 1'b0;
        if (countStart && tick) begin
          if (counter_reg == `TMR_ALL_ZEROS) begin
            counter_next = reload_reg;
            irqEvent     = 1'b1;
            readOverride = 1'b1;
            readValue    = `TMR_ALL_ONES;
          end else begin
            counter_next = counter_reg - 16'h0001;
          end
        end
      end
      `TMR_MODE_EVENT: begin
        // wrap reads all ones on underflow, zeros on overflow
        out_next = 1'b0;
        if (countStart && pinEdge) begin
          if (!countUp && counter_reg == `TMR_ALL_ZEROS) begin
            counter_next = freeRun ? `TMR_ALL_ONES : reload_reg;
            irqEvent     = 1'b1;
            readOverride = 1'b1;
            readValue    = `TMR_ALL_ONES;
          end else if (countUp && counter_reg == `TMR_ALL_ONES) begin
            counter_next = freeRun ? `TMR_ALL_ZEROS : reload_reg;
            irqEvent     = 1'b1;
            readOverride = 1'b1;
            readValue    = `TMR_ALL_ZEROS;
          end else if (countUp) begin
            counter_next = counter_reg + 16'h0001;
          end else begin
            counter_next = counter_reg - 16'h0001;
          end
        end
      end
      `TMR_MODE_ONESHOT: begin
        // stop mid-count: reload, low output, interrupt
        if (startFall && running_reg) begin
          running_next    = 1'b0;
          counter_next    = reload_reg;
          out_next        = 1'b0;
          irqEvent        = 1'b1;
          trigPend_next   = 1'b0;
          retrig_next     = 1'b0;
          reloadSoon_next = 1'b0;
        end else if (countStart) begin
          if (trigEvent && running_reg) begin
            retrig_next = 1'b1;
          end else if (trigEvent) begin
            trigPend_next = 1'b1;
          end
          // pending trigger starts; retrigger counts once more, then reloads
          if (tick) begin
            if (trigPend_reg) begin
              trigPend_next = 1'b0;
              running_next  = 1'b1;
              out_next      = 1'b1;
              counter_next  = reload_reg;
            end else if (running_reg && reloadSoon_reg) begin
              counter_next    = reload_reg;
              reloadSoon_next = 1'b0;
            end else if (running_reg && retrig_reg) begin
              counter_next    = counter_reg - 16'h0001;
              retrig_next     = 1'b0;
              reloadSoon_next = 1'b1;
            end else if (running_reg) begin
              if (counter_reg <= 16'h0001) begin
                running_next = 1'b0;
                out_next     = 1'b0;
                irqEvent     = 1'b1;
                counter_next = reload_reg;
              end else begin
                counter_next = counter_reg - 16'h0001;
              end
            end
          end
        end
      end
      default: begin
        // pwm: high for the reload count, low for the rest of the period
        if (startFall) begin
          running_next = 1'b0;
          if (timer_pulse_output_pin) begin
            out_next = 1'b0;
            irqEvent = 1'b1;
          end
        end else if (countStart && tick) begin
          if (!running_reg) begin
            running_next = 1'b1;
            out_next     = (reload_reg != `TMR_ALL_ZEROS);
            counter_next = reload_reg;
          end else if (counter_reg <= 16'h0001) begin
            if (timer_pulse_output_pin) begin
              out_next     = 1'b0;
              irqEvent     = 1'b1;
              counter_next = `TMR_ALL_ONES - reload_reg;
            end else begin
              out_next     = (reload_reg != `TMR_ALL_ZEROS);
              counter_next = reload_reg;
            end
          end else begin
            counter_next = counter_reg - 16'h0001;
          end
        end
      end
    endcase
    // every write reaches the reload register
    if (counterWrite) begin
      reload_next = counterWriteData;
      // halted write lands in the counter and reads back at once
      if (!countStart || !running_reg && isPulseMode(modeSelect)) begin
        counter_next = counterWriteData;
        readValue    = counterWriteData;
        readOverride = 1'b1;
      end else if (isLevelMode(modeSelect)) begin
        // level modes take the new count even while counting
        counter_next = counterWriteData;
      end
    end
    // read port shows the value the counter is about to hold
    if (!readOverride) begin
      readValue = counter_next;
    end
  end

  // state update, frozen while the clock enable is low
  always @(posedge clock) begin
    if (rst) begin
      // counter and reload cleared, software loads them before use
      counter_reg            <= `TMR_ALL_ZEROS;
      reload_reg             <= `TMR_ALL_ZEROS;
      modePrev_reg           <= `TMR_MODE_TIMER;
      startPrev_reg          <= 1'b0;
      pinPrev_reg            <= 1'b0;
      trigPend_reg           <= 1'b0;
      retrig_reg             <= 1'b0;
      reloadSoon_reg         <= 1'b0;
      running_reg            <= 1'b0;
      timer_pulse_output_pin <= 1'b0;
      irqRequest             <= 1'b0;
      counterReadData        <= `TMR_ALL_ZEROS;
      countActive            <= 1'b0;
    end else if (clockEnable) begin
      // running state is dropped on any mode switch
      if (modeChange) begin
        running_reg            <= 1'b0;
        trigPend_reg           <= 1'b0;
        retrig_reg             <= 1'b0;
        reloadSoon_reg         <= 1'b0;
        timer_pulse_output_pin <= 1'b0;
        counter_reg            <= counter_reg;
      end else begin
        running_reg            <= running_next;
        trigPend_reg           <= trigPend_next;
        retrig_reg             <= retrig_next;
        reloadSoon_reg         <= reloadSoon_next;
        timer_pulse_output_pin <= out_next;
        counter_reg            <= counter_next;
      end
      reload_reg      <= reload_next;
      modePrev_reg    <= modeSelect;
      startPrev_reg   <= countStart;
      pinPrev_reg     <= timer_trigger_input_pin;
      counterReadData <= readValue;
      // a pulse mode counts only once started: one-shot by its trigger, pwm by the first tick
      countActive     <= countStart & (isLevelMode(modeSelect) | (running_next & ~modeChange));
      // set wins over the software clear
      if (modeEntry) begin
        irqRequest <= 1'b1;
      end else if (irqEvent && !modeChange) begin
        irqRequest <= 1'b1;
      end else if (irqWriteZero) begin
        irqRequest <= 1'b0;
      end
    end
  end
endmodule // multimode_down_counter_timer
`default_nettype wire

// *** testbench/timer_monitor.sv ***
// port-level assertions for the timer channel
`timescale 1ns/1ps
`default_nettype none
module timer_monitor #(
  parameter int DIV = 8
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clockEnable,
  input wire logic [1:0]  modeSelect,
  input wire logic        countStart,
  input wire logic        freeRun,
  input wire logic        countUp,
  input wire logic        externalTrigger,
  input wire logic        timer_trigger_input_pin,
  input wire logic        counterWrite,
  input wire logic [15:0] counterWriteData,
  input wire logic        irqWriteZero,
  input wire logic [15:0] counterReadData,
  input wire logic        timer_pulse_output_pin,
  input wire logic        irqRequest,
  input wire logic        countActive
);
  localparam int TRIG_MAX = DIV + 4;
  logic [15:0] reload_reg;
  logic [15:0] edgeVal;
  assign edgeVal = (modeSelect == 2'h1 && countUp) ? 16'hffff : 16'h0000;
  // shadow of the reload value, every write lands there
  always_ff @(posedge clock) begin
    if (rst)
      reload_reg <= 16'h0000;
    else if (counterWrite && clockEnable)
      reload_reg <= counterWriteData;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence dropWithIrq;
    !timer_pulse_output_pin && irqRequest;
  endsequence
  sequence stopNow(m);
    clockEnable && modeSelect == m && $stable(modeSelect) && $fell(countStart);
  endsequence
  sequence steadyCount(m);
    clockEnable && modeSelect == m && $stable(modeSelect) && $stable(countUp) && countActive
    && !$past(counterWrite) && $past(counterReadData) == edgeVal && counterReadData != edgeVal;
  endsequence
  irq_sticky_a: assert property ($fell(irqRequest) |-> $past(irqWriteZero))
    else $error("interrupt bit fell without a clear");
  mode_entry_a: assert property (
    clockEnable && modeSelect[1] && !$past(modeSelect[1]) |=> irqRequest)
    else $error("mode entry did not raise interrupt");
  oneshot_stop_a: assert property (
    stopNow(2'h2) ##0 countActive |=> dropWithIrq ##0 counterReadData == reload_reg)
    else $error("one-shot stop wrong");
  pwm_high_stop_a: assert property (
    stopNow(2'h3) ##0 timer_pulse_output_pin |=> dropWithIrq)
    else $error("pwm stop from high wrong");
  pwm_low_stop_a: assert property (
    stopNow(2'h3) ##0 !timer_pulse_output_pin && !irqRequest
    |=> !timer_pulse_output_pin && !irqRequest)
    else $error("pwm stop from low changed state");
  timer_reload_a: assert property (steadyCount(2'h0) |-> counterReadData == 16'hffff)
    else $error("timer reload read not all ones");
  event_wrap_a: assert property (steadyCount(2'h1) |-> counterReadData == ~edgeVal)
    else $error("event reload read wrong");
  halted_write_a: assert property (
    clockEnable && counterWrite && !countStart && !countActive
    |=> counterReadData == $past(counterWriteData))
    else $error("halted write not read back");
  trigger_delay_a: assert property (
    clockEnable && modeSelect == 2'h2 && $stable(modeSelect) && externalTrigger && countStart
    && !countActive && $rose(timer_trigger_input_pin) |-> ##[1:TRIG_MAX] timer_pulse_output_pin)
    else $error("one-shot output late after trigger");
endmodule // timer_monitor
bind multimode_down_counter_timer timer_monitor #(.DIV(DIV)) monitor (
  .clock(clock), .rst(rst), .clockEnable(clockEnable), .modeSelect(modeSelect),
  .countStart(countStart), .freeRun(freeRun), .countUp(countUp),
  .externalTrigger(externalTrigger), .timer_trigger_input_pin(timer_trigger_input_pin),
  .counterWrite(counterWrite), .counterWriteData(counterWriteData),
  .irqWriteZero(irqWriteZero), .counterReadData(counterReadData),
  .timer_pulse_output_pin(timer_pulse_output_pin), .irqRequest(irqRequest),
  .countActive(countActive));
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the timer channel
`include "timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int DIV = 2;
  logic        clock, rst, clockEnable, countStart, freeRun, countUp, externalTrigger;
  logic        timer_trigger_input_pin, counterWrite, irqWriteZero;
  logic        timer_pulse_output_pin, irqRequest, countActive;
  logic [1:0]  modeSelect;
  logic [15:0] counterWriteData, counterReadData, n;
  int          fails, tests_run, seed;
  multimode_down_counter_timer #(.DIV(DIV)) dut (
    .clock(clock), .rst(rst), .clockEnable(clockEnable), .modeSelect(modeSelect),
    .countStart(countStart), .freeRun(freeRun), .countUp(countUp),
    .externalTrigger(externalTrigger), .timer_trigger_input_pin(timer_trigger_input_pin),
    .counterWrite(counterWrite), .counterWriteData(counterWriteData),
    .irqWriteZero(irqWriteZero), .counterReadData(counterReadData),
    .timer_pulse_output_pin(timer_pulse_output_pin), .irqRequest(irqRequest),
    .countActive(countActive));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] w(input logic b);
    return {15'h0000, b};
  endfunction
  function automatic logic [15:0] wrapRead(input logic up);
    return up ? 16'h0000 : 16'hffff;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    counterWrite = 1;
    counterWriteData = d;
    @(negedge clock);
    counterWrite = 0;
    @(negedge clock);
  endtask
  task automatic clearIrq;
    irqWriteZero = 1;
    @(negedge clock);
    irqWriteZero = 0;
    @(negedge clock);
    chk(w(irqRequest), 16'h0000);
  endtask
  task automatic setMode(input logic [1:0] m);
    modeSelect = m;
    repeat (2) @(negedge clock);
  endtask
  // pin level held for span cycles while looking for exp
  task automatic seek(input logic [15:0] exp, input int span, input logic pin, input logic out);
    logic hit;
    hit = 0;
    timer_trigger_input_pin = pin;
    repeat (span) begin
      @(negedge clock);
      if ((out ? w(timer_pulse_output_pin) : counterReadData) === exp)
        hit = 1;
    end
    timer_trigger_input_pin = 0;
    repeat (4) @(negedge clock);
    chk(w(hit), 16'h0001);
  endtask
  task automatic stopCheck(input logic [15:0] rd);
    countStart = 0;
    repeat (2) @(negedge clock);
    chk(w(timer_pulse_output_pin), 16'h0000);
    chk(w(irqRequest), 16'h0001);
    if (rd != 16'h0000)
      chk(counterReadData, rd);
  endtask
  initial begin
    seed = 71033;
    rst = 1;
    clockEnable = 1;
    modeSelect = `TMR_MODE_TIMER;
    {countStart, freeRun, countUp, externalTrigger} = 4'h0;
    {timer_trigger_input_pin, counterWrite, irqWriteZero} = 3'h0;
    counterWriteData = 16'h0000;
    repeat (12) @(negedge clock);
    rst = 0;
    @(negedge clock);
    chk(counterReadData, 16'h0000);
    repeat (4) begin
      n = 16'($random(seed));
      wr(n);
      chk(counterReadData, n);
    end
    $display("test halted writes done");
    n = {14'h0000, 2'($random(seed))} + 16'h0002;
    wr(n);
    countStart = 1;
    seek(16'hffff, 40, 0, 0);
    chk(w(irqRequest), 16'h0001);
    countStart = 0;
    $display("test timer reload done");
    setMode(`TMR_MODE_EVENT);
    countUp = 1;
    wr(16'hfffe);
    countStart = 1;
    seek(16'hffff, 8, 1, 0);
    seek(wrapRead(1), 8, 1, 0);
    countStart = 0;
    {countUp, freeRun} = 2'b01;
    wr(16'h0001);
    countStart = 1;
    seek(16'h0000, 8, 1, 0);
    seek(wrapRead(0), 8, 1, 0);
    {countStart, freeRun} = 2'b00;
    wr(16'h0005);
    countStart = 1;
    wr(16'hffff);
    seek(16'hfffe, 8, 1, 0);
    {countUp, freeRun} = 2'b11;
    seek(16'hffff, 8, 1, 0);
    seek(wrapRead(1), 8, 1, 0);
    seek(16'h0000, 2, 0, 0);
    {countStart, countUp, freeRun} = 3'b000;
    $display("test event wrap done");
    clearIrq;
    setMode(`TMR_MODE_ONESHOT);
    chk(w(irqRequest), 16'h0001);
    clearIrq;
    wr(16'h0006);
    countStart = 1;
    repeat (4 * DIV) @(negedge clock);
    chk(w(timer_pulse_output_pin), 16'h0001);
    stopCheck(16'h0006);
    clearIrq;
    externalTrigger = 1;
    countStart = 1;
    @(negedge clock);
    seek(16'h0001, DIV + 4, 1, 1);
    countStart = 0;
    externalTrigger = 0;
    repeat (4) @(negedge clock);
    $display("test one-shot done");
    setMode(`TMR_MODE_EVENT);
    clearIrq;
    setMode(`TMR_MODE_PWM);
    chk(w(irqRequest), 16'h0001);
    clearIrq;
    wr(16'h0004);
    countStart = 1;
    @(negedge clock);
    countStart = 0;
    repeat (2) @(negedge clock);
    chk(w(timer_pulse_output_pin), 16'h0000);
    clearIrq;
    countStart = 1;
    repeat (2 * DIV + 1) @(negedge clock);
    chk(w(timer_pulse_output_pin), 16'h0001);
    stopCheck(16'h0000);
    $display("test pwm done");
    tally_and_finish;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
